//--- core/bso_defs.svh
// Constants of the beam switching output evaluation
`ifndef BSO_DEFS_SVH
`define BSO_DEFS_SVH
`define BSO_NUM_BEAMS 32
`define BSO_BEAM_W 5
`define BSO_CNT_W 6
`define BSO_NUM_AREAS 4
`define BSO_AREA_W 2
`define BSO_DEPTH_W 4
`define BSO_TIME_W 16
`define BSO_TIME_MAX_MS 16'hFDE8
`define BSO_CLK_PERIOD_NS 40
`define BSO_MS_NS 1000000
`define BSO_MS_CYCLES (`BSO_MS_NS / `BSO_CLK_PERIOD_NS)
`define BSO_FIRST_BEAM 5'h00
`define BSO_LAST_BEAM 5'h1F
`define BSO_OUT_IDLE 4'hF
`endif

//--- core/bso_pkg.sv
// Types of the beam switching output evaluation
`include "bso_defs.svh"
package bso_pkg;
  typedef enum logic [2:0] {
    BSO_TF_NONE = 3'b000,
    BSO_TF_STARTUP = 3'b001,
    BSO_TF_SWOFF = 3'b010,
    BSO_TF_STRETCH = 3'b011,
    BSO_TF_SUPPRESS = 3'b100
  } bso_tfunc_e;
  typedef struct packed {
    logic dark;
    bso_tfunc_e tfunc;
    logic [`BSO_TIME_W-1:0] time_ms;
    logic [`BSO_AREA_W-1:0] area;
  } bso_out_cfg_s;
  typedef struct packed {
    logic valid;
    logic [`BSO_BEAM_W-1:0] lo;
    logic [`BSO_BEAM_W-1:0] hi;
  } bso_area_s;
endpackage : bso_pkg

//--- core/bso_beam_filter.sv
// Per-beam stability filter over measurement cycles
`timescale 1ns/10ps
`default_nettype none
`include "bso_defs.svh"
module bso_beam_filter (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic meas_tick_i,
  input wire logic [`BSO_NUM_BEAMS-1:0] raw_i,
  input wire logic [`BSO_DEPTH_W-1:0] depth_i,
  output logic [`BSO_NUM_BEAMS-1:0] filt_o
);
  logic [`BSO_NUM_BEAMS-1:0] last_reg;
  logic [`BSO_DEPTH_W-1:0] cnt0;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      last_reg <= '0;
    end else if (meas_tick_i) begin
      last_reg <= raw_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `BSO_NUM_BEAMS; g++) begin : g_beam
      logic [`BSO_DEPTH_W-1:0] cnt_reg;
      logic [`BSO_DEPTH_W-1:0] cnt_next;
      // Counts equal samples, restarting on any raw change
      assign cnt_next = (raw_i[g] != last_reg[g]) ? 4'h1 :
                        (&cnt_reg) ? cnt_reg : cnt_reg + 4'h1;
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          cnt_reg <= '0;
          filt_o[g] <= 1'b0;
        end else if (meas_tick_i) begin
          cnt_reg <= cnt_next;
          if (cnt_next >= depth_i) begin
            filt_o[g] <= raw_i[g];
          end
        end
      end
    end
  endgenerate
  assign cnt0 = g_beam[0].cnt_reg;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_depth_one;
    meas_tick_i && depth_i == 4'h1 |=> filt_o == $past(raw_i);
  endproperty
  a_depth_one: assert property (p_depth_one) else $error("depth one not raw");
  property p_held;
    !meas_tick_i |=> $stable(filt_o);
  endproperty
  a_held: assert property (p_held) else $error("filter moved off tick");
  // Fewer than three equal samples after this tick: the old state must stay
  property p_depth_three;
    meas_tick_i && depth_i == 4'h3 && cnt0 < 4'h2 |=> $stable(filt_o[0]);
  endproperty
  a_depth_three: assert property (p_depth_three) else $error("depth three passed early");
  property p_cnt_restart;
    meas_tick_i && raw_i[0] != last_reg[0] |=> cnt0 == 4'h1;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) else $error("counter not restarted");
endmodule : bso_beam_filter
`default_nettype wire

//--- core/bso_time_func.sv
// Time function of one switching output
`timescale 1ns/10ps
`default_nettype none
`include "bso_defs.svh"
module bso_time_func (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ms_tick_i,
  input wire logic meas_tick_i,
  input wire logic det_i,
  input wire bso_pkg::bso_tfunc_e mode_i,
  input wire logic [`BSO_TIME_W-1:0] time_i,
  output logic q_o
);
  logic det_reg;
  logic [`BSO_TIME_W-1:0] tmr_reg;
  logic [`BSO_TIME_W-1:0] load;
  logic chg;
  logic hold;

  assign load = (time_i > `BSO_TIME_MAX_MS) ? `BSO_TIME_MAX_MS : time_i;
  assign chg = det_i != det_reg;

  // Which direction of change is held back by the timer
  always_comb begin
    unique case (mode_i)
      bso_pkg::BSO_TF_STARTUP: hold = det_i & ~q_o;
      bso_pkg::BSO_TF_SWOFF: hold = ~det_i & q_o;
      bso_pkg::BSO_TF_SUPPRESS: hold = det_i != q_o;
      bso_pkg::BSO_TF_NONE: hold = 1'b0;
      bso_pkg::BSO_TF_STRETCH: hold = 1'b0;
      default: hold = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      det_reg <= 1'b0;
    end else if (meas_tick_i) begin
      det_reg <= det_i;
    end
  end

  // Timer runs in ms, decisions only at measurement cycles
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tmr_reg <= '0;
      q_o <= 1'b0;
    end else begin
      if (ms_tick_i && tmr_reg != '0) begin
        tmr_reg <= tmr_reg - 16'h0001;
      end
      if (meas_tick_i) begin
        if (mode_i == bso_pkg::BSO_TF_STRETCH) begin
          if (tmr_reg == '0 && det_i != q_o) begin
            q_o <= det_i;
            tmr_reg <= load;
          end
        end else if (hold) begin
          if (chg) begin
            tmr_reg <= load;
            if (load == '0) begin
              q_o <= det_i;
            end
          end else if (tmr_reg == '0) begin
            q_o <= det_i;
          end
        end else begin
          q_o <= det_i;
        end
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_none;
    meas_tick_i && mode_i == bso_pkg::BSO_TF_NONE |=> q_o == $past(det_i);
  endproperty
  a_none: assert property (p_none) else $error("plain output lags");
  property p_reload;
    meas_tick_i && hold && chg |=> tmr_reg == $past(load);
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");
  property p_stretch;
    mode_i == bso_pkg::BSO_TF_STRETCH && tmr_reg != '0 |=> $stable(q_o);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch cut short");
  property p_startup;
    meas_tick_i && mode_i == bso_pkg::BSO_TF_STARTUP && det_i && !q_o && !chg &&
      tmr_reg != '0 |=> !q_o;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up too early");
  property p_swoff;
    meas_tick_i && mode_i == bso_pkg::BSO_TF_SWOFF && !det_i && q_o && !chg &&
      tmr_reg != '0 |=> q_o;
  endproperty
  a_swoff: assert property (p_swoff) else $error("switch-off too early");
endmodule : bso_time_func
`default_nettype wire

//--- core/bso_eval.sv
// Beam evaluation, height areas and switching outputs
//
// What this block does
// - Up to four taught height areas, each mappable to an output.
// - Teaching with an object at one end takes all free beams beyond it as one area.
// - Teaching with all beams free takes the whole beam range.
// - Taught height areas combine their blocked beams with OR, their free beams in hole mode.
// - Panel-started teaching assigns the output pins to areas itself.
// - Default light switching: output active while all paths free.
// - Dark switching inverts it: output active on detection.
// - Each output gets one time function of four, or none.
// - Start-up delay 0 to 65000 ms, restarted on re-trigger.
// - Switch-off delay 0 to 65000 ms after object leaves, re-triggered.
// - Pulse stretching holds any new output state for the set time.
// - Pulse suppression switches only after a condition lasts set time.
// - Time functions are judged once per measurement cycle.
// - A changed beam passes on only after filter depth equal cycles.
// - Filter depth one forwards raw beams every cycle.
// - Filter depth three forwards only states stable three cycles.
// - Hole mode: a free beam inside an all-blocked area switches.
// - Area bounds may track first and last blocked beams live.
// - Count of all blocked beams of the current cycle.
// - OR area bit is 1 with any blocked beam inside the area, else 0.
`timescale 1ns/10ps
`default_nettype none
`include "bso_defs.svh"
module bso_eval #(
  parameter int MS_DIV = `BSO_MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic meas_tick_i,
  input wire logic [`BSO_NUM_BEAMS-1:0] beams_raw_i,
  input wire logic [`BSO_DEPTH_W-1:0] filt_depth_i,
  input wire logic teach_i,
  input wire logic [`BSO_AREA_W-1:0] teach_area_i,
  input wire logic teach_panel_i,
  input wire logic [`BSO_NUM_AREAS-1:0] hole_mode_i,
  input wire logic [`BSO_NUM_AREAS-1:0] track_i,
  input wire logic map_load_i,
  input wire bso_pkg::bso_out_cfg_s [`BSO_NUM_AREAS-1:0] out_cfg_i,
  output logic switch_out_first_o,
  output logic switch_out_second_o,
  output logic switch_out_third_o,
  output logic switch_out_fourth_o,
  output logic [`BSO_BEAM_W-1:0] first_blocked_beam_o,
  output logic [`BSO_BEAM_W-1:0] last_blocked_beam_o,
  output logic [`BSO_CNT_W-1:0] blocked_beam_count_o,
  output logic any_blocked_o,
  output logic [`BSO_NUM_AREAS-1:0] area_valid_o,
  output logic teach_done_o,
  output logic teach_error_o
);

  // ---------------------------------------------------------------
  // Millisecond enable
  // ---------------------------------------------------------------
  logic [14:0] ms_cnt_reg;
  logic ms_tick_reg;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == 15'(MS_DIV - 1)) begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 15'h0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Beam filter
  // ---------------------------------------------------------------
  logic [`BSO_NUM_BEAMS-1:0] beams_filt;

  bso_beam_filter u_filter (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .meas_tick_i(meas_tick_i),
    .raw_i(beams_raw_i),
    .depth_i(filt_depth_i),
    .filt_o(beams_filt)
  );

  // ---------------------------------------------------------------
  // First, last and count of blocked beams
  // ---------------------------------------------------------------
  logic [`BSO_BEAM_W-1:0] fib_c;
  logic [`BSO_BEAM_W-1:0] lib_c;
  logic [`BSO_CNT_W-1:0] cnt_c;
  logic any_c;

  always_comb begin
    fib_c = `BSO_FIRST_BEAM;
    lib_c = `BSO_FIRST_BEAM;
    cnt_c = '0;
    for (int i = `BSO_NUM_BEAMS - 1; i >= 0; i--) begin
      if (beams_filt[i]) begin
        fib_c = 5'(i);
      end
    end
    for (int i = 0; i < `BSO_NUM_BEAMS; i++) begin
      if (beams_filt[i]) begin
        lib_c = 5'(i);
      end
      cnt_c = cnt_c + {5'h00, beams_filt[i]};
    end
    any_c = |beams_filt;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      first_blocked_beam_o <= '0;
      last_blocked_beam_o <= '0;
      blocked_beam_count_o <= '0;
      any_blocked_o <= 1'b0;
    end else begin
      first_blocked_beam_o <= fib_c;
      last_blocked_beam_o <= lib_c;
      blocked_beam_count_o <= cnt_c;
      any_blocked_o <= any_c;
    end
  end

  // ---------------------------------------------------------------
  // Height area teaching
  // ---------------------------------------------------------------
  bso_pkg::bso_area_s area_reg [`BSO_NUM_AREAS];
  bso_pkg::bso_area_s taught_c;
  logic teach_ok_c;
  logic [`BSO_AREA_W-1:0] map_reg [`BSO_NUM_AREAS];

  always_comb begin
    taught_c.valid = 1'b1;
    taught_c.lo = `BSO_FIRST_BEAM;
    taught_c.hi = `BSO_LAST_BEAM;
    teach_ok_c = 1'b1;
    if (!any_c) begin
      teach_ok_c = 1'b1;
    end else if (beams_filt[0] && lib_c != `BSO_LAST_BEAM) begin
      taught_c.lo = lib_c + 5'h01;
    end else if (beams_filt[`BSO_NUM_BEAMS-1] && fib_c != `BSO_FIRST_BEAM) begin
      taught_c.hi = fib_c - 5'h01;
    end else begin
      teach_ok_c = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int a = 0; a < `BSO_NUM_AREAS; a++) begin
        area_reg[a] <= '0;
      end
      teach_done_o <= 1'b0;
      teach_error_o <= 1'b0;
    end else begin
      teach_done_o <= teach_i && teach_ok_c;
      teach_error_o <= teach_i && !teach_ok_c;
      if (teach_i && teach_ok_c) begin
        area_reg[teach_area_i] <= taught_c;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      for (int a = 0; a < `BSO_NUM_AREAS; a++) begin
        map_reg[a] <= 2'(a);
      end
    end else if (teach_i && teach_panel_i && teach_ok_c) begin
      map_reg[teach_area_i] <= teach_area_i;
    end else if (map_load_i) begin
      for (int a = 0; a < `BSO_NUM_AREAS; a++) begin
        map_reg[a] <= out_cfg_i[a].area;
      end
    end
  end

  // ---------------------------------------------------------------
  // Area states
  // ---------------------------------------------------------------
  logic [`BSO_NUM_AREAS-1:0] area_det;

  genvar ga;
  generate
    for (ga = 0; ga < `BSO_NUM_AREAS; ga++) begin : g_area
      logic en;
      logic [`BSO_BEAM_W-1:0] lo;
      logic [`BSO_BEAM_W-1:0] hi;
      logic [`BSO_NUM_BEAMS-1:0] mask;
      assign en = track_i[ga] ? any_blocked_o : area_reg[ga].valid;
      assign lo = track_i[ga] ? first_blocked_beam_o : area_reg[ga].lo;
      assign hi = track_i[ga] ? last_blocked_beam_o : area_reg[ga].hi;
      always_comb begin
        mask = '0;
        for (int b = 0; b < `BSO_NUM_BEAMS; b++) begin
          mask[b] = en && 5'(b) >= lo && 5'(b) <= hi;
        end
      end
      // OR of blocked beams, or of free beams when looking for holes
      assign area_det[ga] = hole_mode_i[ga] ? |(mask & ~beams_filt)
                                            : |(mask & beams_filt);
      assign area_valid_o[ga] = area_reg[ga].valid;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Time functions and switching outputs
  // ---------------------------------------------------------------
  logic [`BSO_NUM_AREAS-1:0] det_sel;
  logic [`BSO_NUM_AREAS-1:0] tf_q;
  logic [`BSO_NUM_AREAS-1:0] sw_reg;

  genvar go;
  generate
    for (go = 0; go < `BSO_NUM_AREAS; go++) begin : g_out
      assign det_sel[go] = area_det[map_reg[go]];
      bso_time_func u_tf (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ms_tick_i(ms_tick_reg),
        .meas_tick_i(meas_tick_i),
        .det_i(det_sel[go]),
        .mode_i(out_cfg_i[go].tfunc),
        .time_i(out_cfg_i[go].time_ms),
        .q_o(tf_q[go])
      );
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sw_reg <= `BSO_OUT_IDLE;
    end else begin
      for (int k = 0; k < `BSO_NUM_AREAS; k++) begin
        // Light switching is active while free
        sw_reg[k] <= out_cfg_i[k].dark ? tf_q[k] : ~tf_q[k];
      end
    end
  end

  assign switch_out_first_o = sw_reg[0];
  assign switch_out_second_o = sw_reg[1];
  assign switch_out_third_o = sw_reg[2];
  assign switch_out_fourth_o = sw_reg[3];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_or_area;
    !hole_mode_i[0] && !track_i[0] && area_reg[0].valid &&
      beams_filt[area_reg[0].lo] |-> area_det[0];
  endproperty
  a_or_area: assert property (p_or_area) else $error("OR area missed beam");

  property p_teach_free;
    teach_i && beams_filt == '0 && teach_area_i == 2'h0 |=>
      area_reg[0].valid && area_reg[0].lo == 5'h00 && area_reg[0].hi == 5'h1F;
  endproperty
  a_teach_free: assert property (p_teach_free) else $error("free teach not full");

  property p_teach_mid;
    teach_i && !beams_filt[0] && !beams_filt[`BSO_NUM_BEAMS-1] && beams_filt != '0
      |=> teach_error_o && !teach_done_o;
  endproperty
  a_teach_mid: assert property (p_teach_mid) else $error("middle object taught");

  property p_teach_low;
    teach_i && beams_filt[0] && !beams_filt[`BSO_NUM_BEAMS-1] |=>
      area_reg[$past(teach_area_i)].hi == 5'h1F &&
      area_reg[$past(teach_area_i)].lo == 5'($past(lib_c) + 5'h01);
  endproperty
  a_teach_low: assert property (p_teach_low) else $error("area above object wrong");

  property p_panel;
    teach_i && teach_panel_i && teach_ok_c
      |=> map_reg[$past(teach_area_i)] == $past(teach_area_i);
  endproperty
  a_panel: assert property (p_panel) else $error("panel teach not mapped");

  property p_count;
    1'b1 |=> blocked_beam_count_o == 6'($countones($past(beams_filt)));
  endproperty
  a_count: assert property (p_count) else $error("blocked count wrong");

  sequence s_plain_det(bit want_dark);
    meas_tick_i && out_cfg_i[0].tfunc == bso_pkg::BSO_TF_NONE && det_sel[0] ##1
      out_cfg_i[0].dark == want_dark;
  endsequence
  property p_light;
    s_plain_det(1'b0) ##0 !out_cfg_i[0].dark |=> !switch_out_first_o;
  endproperty
  a_light: assert property (p_light) else $error("light output active on object");
  property p_dark;
    s_plain_det(1'b1) |=> switch_out_first_o;
  endproperty
  a_dark: assert property (p_dark) else $error("dark output idle on object");
endmodule : bso_eval
`default_nettype wire

//--- tb/bso_plc_model.sv
// Controller model that reads the four switching outputs
`timescale 1ns/10ps
`default_nettype none
module bso_plc_model (
  input wire logic clock_i,
  input wire logic [3:0] outs_i,
  output logic [3:0] seen_o
);
  // --------------------------------------------------------------
  // Input card scan
  // --------------------------------------------------------------
  // One register stage, as the controller's input card latches its pins
  always_ff @(posedge clock_i) begin
    seen_o <= outs_i;
  end
endmodule : bso_plc_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench of the beam switching output evaluation
`timescale 1ns/10ps
`default_nettype none
`include "bso_defs.svh"
module tb_top;
  logic clock_i = 1'h0;
  logic resetn_i = 1'h0;
  logic tick = 1'h0;
  logic [31:0] beams = 32'h0;
  logic [3:0] depth = 4'h1;
  logic teach = 1'h0;
  logic [1:0] teach_area = 2'h0;
  logic panel = 1'h0;
  logic [3:0] hole = 4'h0;
  logic [3:0] track = 4'h0;
  logic map_load = 1'h0;
  bso_pkg::bso_out_cfg_s [3:0] cfg = '0;
  wire [3:0] outs;
  logic [3:0] seen;
  logic [4:0] first_blocked_beam;
  logic [4:0] last_blocked_beam;
  logic [5:0] cnt;
  logic any_b;
  logic [3:0] valid;
  logic done;
  logic err;
  int failures = 0;
  int checked = 0;

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  bso_eval #(.MS_DIV(4)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .meas_tick_i(tick),
    .beams_raw_i(beams), .filt_depth_i(depth), .teach_i(teach),
    .teach_area_i(teach_area), .teach_panel_i(panel), .hole_mode_i(hole),
    .track_i(track), .map_load_i(map_load), .out_cfg_i(cfg),
    .switch_out_first_o(outs[0]), .switch_out_second_o(outs[1]),
    .switch_out_third_o(outs[2]), .switch_out_fourth_o(outs[3]),
    .first_blocked_beam_o(first_blocked_beam), .last_blocked_beam_o(last_blocked_beam),
    .blocked_beam_count_o(cnt), .any_blocked_o(any_b), .area_valid_o(valid),
    .teach_done_o(done), .teach_error_o(err)
  );

  bso_plc_model u_plc (.clock_i(clock_i), .outs_i(outs), .seen_o(seen));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step

  // One measurement cycle with the given raw beams, then one idle clock
  task automatic meas(input logic [31:0] b);
    beams = b;
    tick = 1'h1;
    step(1);
    tick = 1'h0;
    step(1);
  endtask : meas

  // Two ticks with the same beams: outputs judge the beams filtered one tick earlier
  task automatic settle(input logic [31:0] b);
    meas(b);
    step(1);
    meas(b);
    step(2);
  endtask : settle

  // One measurement cycle every ten clocks
  task automatic cyc(input logic [31:0] b);
    meas(b);
    step(8);
  endtask : cyc

  task automatic load_map();
    map_load = 1'h1;
    step(1);
    map_load = 1'h0;
    step(1);
  endtask : load_map

  task automatic do_teach(input logic [1:0] a, input logic pnl, input logic exp_err);
    int d;
    int e;
    d = 0;
    e = 0;
    teach_area = a;
    panel = pnl;
    teach = 1'h1;
    step(1);
    teach = 1'h0;
    panel = 1'h0;
    repeat (3) begin
      d += (done === 1'h1);
      e += (err === 1'h1);
      step(1);
    end
    chk("teach done", d, !exp_err);
    chk("teach error", e, exp_err);
  endtask : do_teach

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk("outputs idle", seen, 4'hF);
    chk("count", {any_b, cnt}, 7'h00);
    chk("area valid", valid, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_filter();
    meas(32'h0000_00F0);
    step(1);
    chk("count d1", {any_b, cnt, first_blocked_beam, last_blocked_beam}, {1'h1, 6'h04, 5'h04, 5'h07});
    depth = 4'h3;
    meas(32'h0000_0003);
    meas(32'h0000_0003);
    step(1);
    chk("count 2 ticks", cnt, 6'h04);
    meas(32'h0000_00F0);
    meas(32'h0000_0003);
    meas(32'h0000_0003);
    step(1);
    chk("count after glitch", cnt, 6'h04);
    meas(32'h0000_0003);
    step(1);
    chk("count d3", {cnt, first_blocked_beam, last_blocked_beam}, {6'h02, 5'h00, 5'h01});
    depth = 4'h1;
    meas(32'h0);
    step(1);
    chk("count clear", {any_b, cnt}, 7'h00);
    $display("test filter done");
  endtask : t_filter

  task automatic t_teach();
    cfg[3].area = 2'h0;
    load_map();
    do_teach(2'h0, 1'h0, 1'h0);
    meas(32'h0000_000F);
    do_teach(2'h1, 1'h0, 1'h0);
    meas(32'h0000_0F00);
    do_teach(2'h2, 1'h0, 1'h1);
    meas(32'hFFF0_0000);
    do_teach(2'h3, 1'h1, 1'h0);
    chk("area valid", valid, 4'hB);
    settle(32'h0000_0004);
    chk("outs beam2", seen, 4'h6);
    settle(32'h0200_0000);
    chk("outs beam25", seen, 4'hC);
    settle(32'h0);
    chk("outs free", seen, 4'hF);
    $display("test teach done");
  endtask : t_teach

  task automatic t_dark();
    cfg[0].dark = 1'h1;
    cfg[1].dark = 1'h1;
    settle(32'h0200_0000);
    chk("dark detect", seen, 4'hF);
    settle(32'h0);
    chk("dark free", seen, 4'hC);
    cfg[0].dark = 1'h0;
    cfg[1].dark = 1'h0;
    $display("test dark done");
  endtask : t_dark

  task automatic t_hole();
    hole = 4'h1;
    settle(32'hFFFF_FFFF);
    chk("hole none", seen[0], 1'h1);
    settle(32'hFFFF_FF7F);
    chk("hole found", seen[0], 1'h0);
    track = 4'h1;
    settle(32'h0000_03F8);
    chk("track none", seen[0], 1'h1);
    settle(32'h0000_03B8);
    chk("track hole", seen[0], 1'h0);
    hole = 4'h0;
    track = 4'h0;
    settle(32'h0);
    $display("test hole done");
  endtask : t_hole

  // Ticks every 10 clocks; 5 ms is 20 clocks with the short divider
  task automatic t_time();
    cfg[0].tfunc = bso_pkg::BSO_TF_STARTUP;
    cfg[1].tfunc = bso_pkg::BSO_TF_SWOFF;
    cfg[2].tfunc = bso_pkg::BSO_TF_STRETCH;
    cfg[3].tfunc = bso_pkg::BSO_TF_SUPPRESS;
    for (int k = 0; k < 4; k++) begin
      cfg[k].area = 2'h0;
      cfg[k].time_ms = 16'h0005;
    end
    load_map();
    cyc(32'h0000_0100);
    cyc(32'h0);
    chk("tf pulse on", seen, 4'h9);
    cyc(32'h0);
    chk("tf pulse off", seen, 4'h9);
    repeat (5) begin
      cyc(32'h0);
    end
    chk("tf expired", seen, 4'hF);
    cyc(32'h0000_0100);
    cyc(32'h0000_0100);
    chk("tf long on", seen, 4'h9);
    cyc(32'h0000_0100);
    chk("tf long wait", seen, 4'h9);
    repeat (4) begin
      cyc(32'h0000_0100);
    end
    chk("tf long held", seen, 4'h0);
    $display("test time done");
  endtask : t_time

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    for (int k = 0; k < 4; k++) begin
      cfg[k].area = k[1:0];
    end
    repeat (16) @(posedge clock_i);
    #1;
    resetn_i = 1'h1;
    t_reset();
    t_filter();
    t_teach();
    t_dark();
    t_hole();
    t_time();
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge clock_i);
    failures++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
